// ===== hdl/bph_cfg.svh
// Purpose: constants for the power handshake controller
// Assumes: 40 MHz pclk, apb word registers
// Notes: offsets are byte addresses
`ifndef BPH_CFG_SVH
`define BPH_CFG_SVH
`define BPH_CLK_HZ 40000000
`define BPH_LPO_HZ 32768
`define BPH_OFF_CTRL 12'h000
`define BPH_OFF_SLEEP 12'h004
`define BPH_OFF_RF 12'h008
`define BPH_OFF_STAT 12'h00c
`define BPH_OFF_PADFN 12'h010
`define BPH_CTRL_RST 32'h0000_0000
`define BPH_PADFN_PWR 2'h0
`define BPH_CTRL_HS_EN 0
`define BPH_CTRL_UART 1
`define BPH_CTRL_DEVPOL 2
`define BPH_CTRL_HOSTPOL 3
`define BPH_CTRL_HOSTREQ 4
`define BPH_CTRL_SLEEPREQ 5
`define BPH_CTRL_SHUTDOWN 6
`define BPH_CTRL_DYN_RF 7
`define BPH_SLEEP_RST 32'h0000_0020
`define BPH_WAKE_RST 20'h0_0000
`endif

// ===== hdl/bph_ctrl.sv
// Purpose: bluetooth power management and host wake handshake
// Assumes: apb slave, low-power oscillator sampled as a pin
// Notes: shutdown is left only through presetn
// Behaviour
// RULE1 - power requests come from software registers and baseband packet activity
// RULE2 - separate transmit, receive, pll and amplifier power-down outputs
// RULE3 - handshake pins only work in uart mode after being enabled
// RULE4 - asserted host wake input forces exit from sleep and keeps awake
// RULE5 - sleep only when host wake deasserted and internal criteria met
// RULE6 - host keeps its wake line asserted while device must stay awake
// RULE7 - device asserts its host wake output when it needs the host
// RULE8 - host stays awake while device wake output is asserted
// RULE9 - both wake lines have software selectable polarity
// RULE10 - clock request is active high when bluetooth or wlan needs it
// RULE11 - pad function for the handshake pins must be zero
// RULE12 - rf powered only during active transmit or receive windows
// RULE13 - sniff and hold sleep on oscillator and wake after programmed time
// RULE14 - low-power oscillator input is a 32.768 khz clock
// RULE15 - shutdown removes rf and core supplies, io supply kept
// RULE16 - in shutdown all outputs tristated, most inputs ignored; here only device_to_host_wake and ref_clock_request float
// RULE17 - leaving shutdown is a full reset with no retained state
// RULE18 - host wake input passes two flops before use
//
// The address map and the APB interface to the registers are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "bph_cfg.svh"
module bph_ctrl #(
   parameter int WAKE_W = 20
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire bph_pkg::bph_bb_s bb_in,
   input wire logic wlan_clk_need,
   input wire logic host_to_device_wake,
   input wire logic low_power_osc_input,
   output bph_pkg::bph_rf_pd_s rf_pd,
   output logic device_to_host_wake,
   output logic device_to_host_wake_oe_n,
   output logic ref_clock_request,
   output logic ref_clock_request_oe_n,
   output logic rf_supply_en,
   output logic core_supply_en,
   output logic lpo_clk_sel
);
   import bph_pkg::*;
   localparam int LPO_HZ = `BPH_LPO_HZ;
   logic [31:0] ctrl_q, ctrl_d;
   logic [WAKE_W-1:0] wake_q, wake_d;
   logic [1:0] padfn_q, padfn_d;
   logic [WAKE_W-1:0] cnt_q, cnt_d;
   bph_state_e st_q, st_d;
   bph_rf_pd_s rf_q, rf_d;
   logic hw_q, hw_d, clk_q, clk_d;
   logic [31:0] rd_q, rd_d;
   logic dev_wake_s, lpo_s, lpo_prev_q, lpo_tick;
   logic hs_ok, dev_wake_act, wr, rd;
   function automatic logic hit(input logic [11:0] a, input logic [11:0] off);
      hit = (a == off);
   endfunction
   bph_sync u_wake_sync (
      .clk(pclk),
      .rst_n(presetn),
      .d(host_to_device_wake),
      .q(dev_wake_s)
   ); // RULE18
   bph_sync u_lpo_sync (
      .clk(pclk),
      .rst_n(presetn),
      .d(low_power_osc_input),
      .q(lpo_s)
   ); // RULE14
   // oscillator edge gives the sleep timebase; pclk must keep running in this model
   assign lpo_tick = lpo_s & ~lpo_prev_q; // RULE13
   assign wr = psel & penable & pwrite;
   assign rd = psel & ~penable & ~pwrite;
   assign pready = 1'b1;
   assign pslverr = psel & penable & ~(hit(paddr, `BPH_OFF_CTRL) | hit(paddr, `BPH_OFF_SLEEP) |
      hit(paddr, `BPH_OFF_RF) | hit(paddr, `BPH_OFF_STAT) | hit(paddr, `BPH_OFF_PADFN));
   assign prdata = rd_q;
   // handshake pins usable only in uart mode, when enabled and pads select power function
   assign hs_ok = ctrl_q[`BPH_CTRL_HS_EN] & ctrl_q[`BPH_CTRL_UART] & (padfn_q == `BPH_PADFN_PWR); // RULE3 RULE11
   assign dev_wake_act = hs_ok & (dev_wake_s ^ ctrl_q[`BPH_CTRL_DEVPOL]); // RULE9
   always_comb begin
      ctrl_d = ctrl_q;
      wake_d = wake_q;
      padfn_d = padfn_q;
      rd_d = rd_q;
      if (wr && hit(paddr, `BPH_OFF_CTRL)) begin
         ctrl_d = pwdata; // RULE1
      end
      if (wr && hit(paddr, `BPH_OFF_SLEEP)) begin
         wake_d = pwdata[WAKE_W-1:0];
      end
      if (wr && hit(paddr, `BPH_OFF_PADFN)) begin
         padfn_d = pwdata[1:0];
      end
      if (rd) begin
         rd_d = 32'h0000_0000;
         if (hit(paddr, `BPH_OFF_CTRL)) begin
            rd_d = ctrl_q;
         end else if (hit(paddr, `BPH_OFF_SLEEP)) begin
            rd_d[WAKE_W-1:0] = wake_q;
         end else if (hit(paddr, `BPH_OFF_RF)) begin
            rd_d[3:0] = rf_q;
         end else if (hit(paddr, `BPH_OFF_STAT)) begin
            rd_d[3:0] = st_q;
            rd_d[4] = dev_wake_act;
            rd_d[5] = hw_q;
            rd_d[6] = clk_q;
         end else if (hit(paddr, `BPH_OFF_PADFN)) begin
            rd_d[1:0] = padfn_q;
         end
      end
   end
   always_comb begin
      st_d = st_q;
      cnt_d = cnt_q;
      case (st_q)
         BPH_ACTIVE: begin
            if (ctrl_q[`BPH_CTRL_SHUTDOWN]) begin
               st_d = BPH_SHUT; // RULE15
            end else if (!dev_wake_act && bb_in.bb_sleep_ok &&
                         (ctrl_q[`BPH_CTRL_SLEEPREQ] || bb_in.bb_sniff_hold)) begin
               st_d = BPH_SLEEP; // RULE5 RULE1
               cnt_d = wake_q;
            end
         end
         BPH_SLEEP: begin
            if (dev_wake_act || ctrl_q[`BPH_CTRL_SHUTDOWN]) begin
               st_d = ctrl_q[`BPH_CTRL_SHUTDOWN] ? BPH_SHUT : BPH_WAKE; // RULE4
            end else if (lpo_tick) begin
               if (cnt_q == '0) begin
                  st_d = BPH_WAKE; // RULE13
               end else begin
                  cnt_d = cnt_q - 1'b1;
               end
            end
         end
         BPH_WAKE: begin
            st_d = BPH_ACTIVE;
         end
         // only presetn leaves shutdown, so no state survives it
         BPH_SHUT: begin
            st_d = BPH_SHUT; // RULE17
         end
         default: begin
            st_d = BPH_ACTIVE;
         end
      endcase
   end
   always_comb begin
      logic awake;
      awake = (st_q == BPH_ACTIVE);
      // dynamic gating: power each path only while its packet window is open
      rf_d.tx_pd = !(awake && (bb_in.bb_tx_active || !ctrl_q[`BPH_CTRL_DYN_RF])); // RULE2 RULE12
      rf_d.rx_pd = !(awake && (bb_in.bb_rx_active || !ctrl_q[`BPH_CTRL_DYN_RF])); // RULE2 RULE12
      rf_d.pll_pd = !(awake && (bb_in.bb_tx_active || bb_in.bb_rx_active || !ctrl_q[`BPH_CTRL_DYN_RF])); // RULE2
      rf_d.pa_pd = !(awake && (bb_in.bb_tx_active || !ctrl_q[`BPH_CTRL_DYN_RF])); // RULE2
      hw_d = hs_ok && (st_q != BPH_SHUT) && (bb_in.bb_host_attn || ctrl_q[`BPH_CTRL_HOSTREQ]); // RULE7
      clk_d = (st_q != BPH_SHUT) && (awake || wlan_clk_need || (st_q == BPH_WAKE)); // RULE10
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_q <= `BPH_CTRL_RST;
         wake_q <= WAKE_W'(`BPH_SLEEP_RST);
         padfn_q <= `BPH_PADFN_PWR;
         rd_q <= 32'h0000_0000;
         st_q <= BPH_ACTIVE;
         cnt_q <= '0;
         rf_q <= 4'hf;
         hw_q <= 1'b0;
         clk_q <= 1'b0;
         lpo_prev_q <= 1'b0;
      end else begin
         ctrl_q <= ctrl_d;
         wake_q <= wake_d;
         padfn_q <= padfn_d;
         rd_q <= rd_d;
         st_q <= st_d;
         cnt_q <= cnt_d;
         rf_q <= rf_d;
         hw_q <= hw_d;
         clk_q <= clk_d;
         lpo_prev_q <= lpo_s;
      end
   end
   assign rf_pd = rf_q;
   assign device_to_host_wake = hw_q ^ ctrl_q[`BPH_CTRL_HOSTPOL]; // RULE9
   // in shutdown device_to_host_wake and ref_clock_request float; enables are active low
   assign device_to_host_wake_oe_n = (st_q == BPH_SHUT) || !hs_ok; // RULE16
   assign ref_clock_request_oe_n = (st_q == BPH_SHUT); // RULE16
   assign ref_clock_request = clk_q;
   assign rf_supply_en = (st_q != BPH_SHUT); // RULE15
   assign core_supply_en = (st_q != BPH_SHUT); // RULE15
   assign lpo_clk_sel = (st_q == BPH_SLEEP); // RULE13
endmodule
`default_nettype wire

// ===== hdl/bph_pkg.sv
// Purpose: types for the power handshake controller
// Assumes: included constants header
// Notes: one-hot sleep states
package bph_pkg;
   typedef enum logic [3:0] {
      BPH_ACTIVE = 4'h1,
      BPH_SLEEP = 4'h2,
      BPH_SHUT = 4'h4,
      BPH_WAKE = 4'h8
   } bph_state_e;
   typedef struct packed {
      logic tx_pd;
      logic rx_pd;
      logic pll_pd;
      logic pa_pd;
   } bph_rf_pd_s;
   typedef struct packed {
      logic bb_tx_active;
      logic bb_rx_active;
      logic bb_sleep_ok;
      logic bb_sniff_hold;
      logic bb_host_attn;
   } bph_bb_s;
endpackage

// ===== hdl/bph_sync.sv
// Purpose: two flop synchroniser for one level
// Assumes: input is asynchronous to clk
// Notes: first stage read only by second
`timescale 1ns/1ps
`default_nettype none
module bph_sync (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic d,
   output logic q
);
   logic meta_q;
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         meta_q <= 1'b0;
         q <= 1'b0;
      end else begin
         meta_q <= d;
         q <= meta_q;
      end
   end
endmodule
`default_nettype wire

// ===== verification/bph_ctrl_monitor.sv
// Purpose: port checks for the power handshake controller
// Assumes: both wake polarity bits written equal
// Notes: mirrors ctrl and pad writes to know the enables
`timescale 1ns/1ps
`default_nettype none
module bph_ctrl_monitor (
   input wire logic pclk, presetn, psel, penable, pwrite, pslverr, wlan_clk_need, host_to_device_wake,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire bph_pkg::bph_bb_s bb_in,
   input wire bph_pkg::bph_rf_pd_s rf_pd,
   input wire logic device_to_host_wake, device_to_host_wake_oe_n, ref_clock_request, ref_clock_request_oe_n,
   input wire logic rf_supply_en, core_supply_en, lpo_clk_sel
);
   import bph_pkg::*;
   logic [7:0] ctl_q;
   logic [1:0] pad_q;
   logic en;
   logic act;
   assign en = ctl_q[1:0] == 2'h3 && pad_q == 2'h0 && ctl_q[2] == ctl_q[3];
   assign act = host_to_device_wake ^ ctl_q[3];
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctl_q <= 8'h00;
         pad_q <= 2'h0;
      end else if (psel && penable && pwrite) begin
         if (paddr == 12'h000) ctl_q <= pwdata[7:0];
         if (paddr == 12'h010) pad_q <= pwdata[1:0];
      end
   end
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   property p_unmap; psel && penable && paddr > 12'h010 |-> pslverr; endproperty
   a_unmap: assert property (p_unmap) else $error("no error on unmapped access");
   property p_rf; ctl_q[7] && !lpo_clk_sel && core_supply_en ##1 core_supply_en |->
      rf_pd.tx_pd == !$past(bb_in.bb_tx_active) && rf_pd.rx_pd == !$past(bb_in.bb_rx_active) &&
      rf_pd.pa_pd == !$past(bb_in.bb_tx_active) &&
      rf_pd.pll_pd == !($past(bb_in.bb_tx_active) || $past(bb_in.bb_rx_active)); endproperty
   a_rf: assert property (p_rf) else $error("rf gating wrong");
   property p_clk; wlan_clk_need && core_supply_en ##1 core_supply_en |-> ref_clock_request; endproperty
   a_clk: assert property (p_clk) else $error("clock request missing");
   property p_shut; rf_supply_en == core_supply_en &&
      (core_supply_en || (device_to_host_wake_oe_n && ref_clock_request_oe_n)); endproperty
   a_shut: assert property (p_shut) else $error("shutdown outputs wrong");
   property p_stay; !core_supply_en |=> !core_supply_en; endproperty
   a_stay: assert property (p_stay) else $error("shutdown left without reset");
   property p_oe; ($stable(ctl_q) && $stable(pad_q)) [*2] |->
      device_to_host_wake_oe_n == !(ctl_q[1:0] == 2'h3 && pad_q == 2'h0) || !core_supply_en; endproperty
   a_oe: assert property (p_oe) else $error("wake output enable wrong");
   property p_dwake; en && bb_in.bb_host_attn ##1 $stable(ctl_q) && core_supply_en |->
      device_to_host_wake == !ctl_q[2]; endproperty
   a_dwake: assert property (p_dwake) else $error("wake output level wrong");
   property p_hwake; (en && act && core_supply_en) [*6] |-> !lpo_clk_sel; endproperty
   a_hwake: assert property (p_hwake) else $error("asleep while host wake held");
endmodule
`default_nettype wire

// ===== verification/bph_ctrl_tb.sv
// Purpose: self-checking bench for the power handshake controller
// Assumes: zero wait apb, both wake polarity bits kept equal
// Notes: oscillator sped up to 16 cycle halves so sleeps stay short
`timescale 1ns/1ps
`default_nettype none
`include "bph_cfg.svh"
`define CHK(n, e, s) begin comparisons++; if ((s) !== (e)) begin errors++; $display("unexpected %s exp %h got %h", n, e, s); end end
module bph_ctrl_tb;
   import bph_pkg::*;
   logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pol = 0, need = 0;
   logic wlan_clk_need = 0, low_power_osc_input = 0, pready, pslverr, lpo_clk_sel, awake;
   logic device_to_host_wake, device_to_host_wake_oe_n, ref_clock_request, ref_clock_request_oe_n;
   logic host_to_device_wake, rf_supply_en, core_supply_en;
   logic [11:0] paddr = 0;
   logic [31:0] pwdata = 0, prdata, rd, v;
   bph_bb_s bb_in = '0;
   bph_rf_pd_s rf_pd;
   int errors = 0, comparisons = 0, seed = 32'h525e3873, ticks;
   bph_ctrl DUT (.*);
   bph_host_model host (.pol, .need, .dev_wake(device_to_host_wake), .dev_wake_oe_n(device_to_host_wake_oe_n),
      .host_wake(host_to_device_wake), .awake);
   initial forever #12.5 pclk = ~pclk;
   function logic [31:0] ctl(input logic [3:0] hi);
      return {24'h0, hi, pol, pol, 2'h3};
   endfunction
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      psel <= 1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      psel <= 0;
      penable <= 0;
      @(posedge pclk);
   endtask
   task wsel(input logic e);
      repeat (12) if (lpo_clk_sel !== e) @(posedge pclk);
      `CHK("sleep_sel", e, lpo_clk_sel)
   endtask
   task close_out;
      $display("comparisons %0d errors %0d", comparisons, errors);
      if (errors == 0 && comparisons > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   // the tests need under 2000 cycles
   initial begin
      #(25 * 20000);
      errors++;
      close_out;
   end
   initial begin
      repeat (4) @(posedge pclk);
      presetn <= 1;
      apb(0, `BPH_OFF_CTRL, 0);
      `CHK("ctrl", `BPH_CTRL_RST, rd)
      apb(0, `BPH_OFF_SLEEP, 0);
      `CHK("count", `BPH_SLEEP_RST, rd)
      apb(0, 12'h020, 0);
      `CHK("unmapped", 32'h0, rd)
      v = $random(seed) & 32'hfffff;
      apb(1, `BPH_OFF_SLEEP, v);
      apb(0, `BPH_OFF_SLEEP, 0);
      `CHK("count_rw", v, rd)
      for (int p = 0; p < 2; p++) begin
         pol <= p[0];
         apb(1, `BPH_OFF_PADFN, 1);
         apb(1, `BPH_OFF_CTRL, ctl(4'h8));
         `CHK("oe_pad", 1'b1, device_to_host_wake_oe_n)
         apb(1, `BPH_OFF_PADFN, 0);
         `CHK("oe_on", 1'b0, device_to_host_wake_oe_n)
         bb_in.bb_host_attn <= 1;
         wlan_clk_need <= 1;
         repeat (40) begin
            @(posedge pclk);
            bb_in[4:3] <= 2'($random(seed));
         end
         `CHK("dev_wake", ~pol, device_to_host_wake)
         `CHK("host_up", 1'b1, awake)
         `CHK("clk_req", 1'b1, ref_clock_request)
         bb_in <= 5'h04;
         wlan_clk_need <= 0;
         apb(1, `BPH_OFF_CTRL, ctl(4'ha));
         wsel(1);
         apb(0, `BPH_OFF_STAT, 0);
         `CHK("stat_sleep", 7'h02, rd[6:0])
         need <= 1;
         wsel(0);
         bb_in <= 5'h00;
         need <= 0;
         apb(1, `BPH_OFF_SLEEP, 32'(p + 2));
         apb(1, `BPH_OFF_CTRL, ctl(4'h8));
         bb_in <= 5'h06;
         wsel(1);
         bb_in <= 5'h00;
         ticks = 0;
         while (lpo_clk_sel === 1'b1 && ticks < 9) begin
            ticks += !low_power_osc_input;
            low_power_osc_input <= !low_power_osc_input;
            repeat (16) @(posedge pclk);
         end
         `CHK("ticks", p + 3, ticks)
         $display("test pol %0d done", p);
      end
      apb(1, `BPH_OFF_CTRL, ctl(4'h4));
      repeat (2) @(posedge pclk);
      `CHK("supplies", 2'b00, {rf_supply_en, core_supply_en})
      `CHK("tristate", 2'b11, {device_to_host_wake_oe_n, ref_clock_request_oe_n})
      presetn <= 0;
      @(posedge pclk);
      presetn <= 1;
      `CHK("rf_down", 4'hf, rf_pd)
      apb(0, `BPH_OFF_CTRL, 0);
      `CHK("ctrl_clear", `BPH_CTRL_RST, rd)
      `CHK("supplies_on", 2'b11, {rf_supply_en, core_supply_en})
      $display("test shutdown done");
      close_out;
   end
endmodule
bind bph_ctrl bph_ctrl_monitor mon (.*);
`default_nettype wire

// ===== verification/bph_host_model.sv
// Purpose: host end of the wake handshake
// Assumes: both wake lines share one polarity
// Notes: a released wake line reads as not asserted
`timescale 1ns/1ps
`default_nettype none
module bph_host_model (
   input wire logic pol,
   input wire logic need,
   input wire logic dev_wake,
   input wire logic dev_wake_oe_n,
   output logic host_wake,
   output logic awake
);
   assign host_wake = need ^ pol;
   assign awake = (!dev_wake_oe_n && (dev_wake ^ pol)) || need;
endmodule
`default_nettype wire
